/* hw/crf_pkg.sv */
// Package for the core register file: offsets, flag positions, reset values and carriers
package crf_pkg;
  // AHB register byte offsets (one word each)
  localparam logic [7:0] OFS_DATA0 = 8'h00;
  localparam logic [7:0] OFS_DATA1 = 8'h04;
  localparam logic [7:0] OFS_DATA2 = 8'h08;
  localparam logic [7:0] OFS_DATA3 = 8'h0C;
  localparam logic [7:0] OFS_ADDR0 = 8'h10;
  localparam logic [7:0] OFS_ADDR1 = 8'h14;
  localparam logic [7:0] OFS_FRAME = 8'h18;
  localparam logic [7:0] OFS_PC = 8'h1C;
  localparam logic [7:0] OFS_VTB = 8'h20;
  localparam logic [7:0] OFS_USP = 8'h24;
  localparam logic [7:0] OFS_ISP = 8'h28;
  localparam logic [7:0] OFS_SB = 8'h2C;
  localparam logic [7:0] OFS_FLAG = 8'h30;
  localparam int NUM_REGS = 13;
  // Flag word bit positions
  localparam int FLG_C = 0;
  localparam int FLG_D = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_S = 3;
  localparam int FLG_B = 4;
  localparam int FLG_O = 5;
  localparam int FLG_I = 6;
  localparam int FLG_U = 7;
  localparam int FLG_IPL_LO = 12;
  localparam int FLG_IPL_HI = 14;
  // Implemented bits: 0..7 and 12..14; 8..11 and 15 read zero
  localparam logic [15:0] FLG_MASK = 16'h70FF;
  localparam int SWI_LAST_CLR = 31;
  // Reset values
  localparam logic [15:0] RST_W16 = 16'h0000;
  localparam logic [19:0] RST_W20 = 20'h00000;
  localparam logic [15:0] RST_FLG = 16'h0000;

  // Datapath register selector
  typedef enum logic [3:0] {
    CRF_SEL_D0 = 4'h0, CRF_SEL_D1 = 4'h1, CRF_SEL_D2 = 4'h2, CRF_SEL_D3 = 4'h3,
    CRF_SEL_A0 = 4'h4, CRF_SEL_A1 = 4'h5, CRF_SEL_FB = 4'h6, CRF_SEL_SB = 4'h7,
    CRF_SEL_SP = 4'h8, CRF_SEL_L_LO = 4'h9, CRF_SEL_L_HI = 4'hA, CRF_SEL_L_AD = 4'hB
  } crf_sel_type;

  // Datapath write: size 0 byte, 1 word, 2 long
  typedef struct packed {
    logic en;
    crf_sel_type sel;
    logic [1:0] size;
    logic hi_byte;
    logic [31:0] data;
  } crf_wr_type;

  // ALU flag update
  typedef struct packed {
    logic en;
    logic carry;
    logic zero;
    logic sign;
    logic ovf;
  } crf_alu_type;

  // Interrupt events
  typedef struct packed {
    logic hw_ack;
    logic swi;
    logic [5:0] swi_num;
    logic [2:0] new_ipl;
  } crf_irq_type;

  typedef enum logic [1:0] {
    CRF_ST_IDLE = 2'b00,
    CRF_ST_DATA = 2'b01
  } crf_state_type;
endpackage

/* hw/crf_core.sv */
// Programmer register file with flag word, datapath ports and AHB-Lite access
//
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Thirteen registers; data, address and frame base exist in two banks.
// - Four sixteen-bit data registers read and written by the datapath.
// - First two data registers take byte writes altering only one half.
// - Third:first and fourth:second data registers join as 32-bit operands.
// - Address registers are 16-bit pointers, joinable as 32 bits, second high.
// - Frame base register is sixteen bits, base for frame-relative addressing.
// - Program counter is twenty bits, next instruction address.
// - Vector table base is twenty bits.
// - Separate user and interrupt stack pointers chosen by flag bit 7.
// - Static base register is sixteen bits.
// - Flag word has eleven flags; bits 8 to 11 reserved.
// - Bit 0 holds ALU carry, borrow or shifted-out bit.
// - Bit 1 set raises single-step after each instruction; acknowledge clears it.
// - Bit 2 set on zero result, cleared otherwise.
// - Bit 3 set on negative result, cleared otherwise.
// - Bit 4 selects register bank zero or one.
// - Bit 5 set on overflow, cleared otherwise.
// - Bit 6 enables maskable interrupts; acknowledge clears it.
// - Stack flag zero selects interrupt pointer, one selects user pointer.
// - Stack flag cleared on hardware acknowledge or software vector 0 to 31.
// - Bits 12 to 14 hold the priority level field.
// - Request accepted only if its priority exceeds the current level.
// - Bit 15 reserved, no function.
module crf_core
  import crf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire crf_wr_type dp_wr,
  input wire crf_alu_type alu_upd,
  input wire logic pc_load,
  input wire logic [19:0] pc_value,
  input wire logic insn_done,
  input wire crf_irq_type irq_ev,
  input wire logic [2:0] req_level,
  input wire logic req_valid,
  input wire crf_sel_type rd_sel,
  output logic [31:0] rd_data,
  output logic [15:0] flag_out,
  output logic [19:0] pc_out,
  output logic [19:0] vtb_out,
  output logic [15:0] sp_out,
  output logic step_irq,
  output logic irq_accept
);

  // Banked state: index [bank][0..6] = d0,d1,d2,d3,a0,a1,fb
  logic [15:0] bank_q [2][7];
  logic [15:0] bank_d [2][7];
  logic [15:0] usp_q, usp_d, isp_q, isp_d, sb_q, sb_d, flg_q, flg_d;
  logic [19:0] pc_q, pc_d, vtb_q, vtb_d;
  logic bank_q_sel;
  logic [31:0] rd_d, hrdata_d;
  logic step_d, accept_d;
  logic [15:0] sp_d;
  crf_state_type st_q, st_d;
  logic [7:0] ofs_q, ofs_d;
  logic wr_q, wr_d;

  // Bank latched at the register access: flag change lands next cycle
  assign bank_q_sel = flg_q[FLG_B];

  // Bus address-phase capture; single-cycle data phase, never waits
  always_comb begin
    st_d = st_q;
    ofs_d = ofs_q;
    wr_d = 1'b0;
    if (hsel && hready && htrans[1]) begin
      st_d = CRF_ST_DATA;
      ofs_d = haddr[7:0];
      wr_d = hwrite;
    end else if (hready) begin
      st_d = CRF_ST_IDLE;
    end
  end

  // Register state next values; datapath wins over bus on the same register
  always_comb begin
    logic [15:0] w16;
    logic b;
    w16 = hwdata[15:0];
    b = bank_q_sel;
    bank_d = bank_q;
    usp_d = usp_q;
    isp_d = isp_q;
    sb_d = sb_q;
    pc_d = pc_q;
    vtb_d = vtb_q;
    flg_d = flg_q;
    // Bus writes into the active bank
    if (st_q == CRF_ST_DATA && wr_q) begin
      case (ofs_q)
        OFS_DATA0: bank_d[b][0] = w16;
        OFS_DATA1: bank_d[b][1] = w16;
        OFS_DATA2: bank_d[b][2] = w16;
        OFS_DATA3: bank_d[b][3] = w16;
        OFS_ADDR0: bank_d[b][4] = w16;
        OFS_ADDR1: bank_d[b][5] = w16;
        OFS_FRAME: bank_d[b][6] = w16;
        OFS_PC: pc_d = hwdata[19:0];
        OFS_VTB: vtb_d = hwdata[19:0];
        OFS_USP: usp_d = w16;
        OFS_ISP: isp_d = w16;
        OFS_SB: sb_d = w16;
        OFS_FLAG: flg_d = w16 & FLG_MASK;
        default: ;
      endcase
    end
    // Datapath writes
    if (dp_wr.en) begin
      case (dp_wr.sel)
        CRF_SEL_D0, CRF_SEL_D1: begin
          if (dp_wr.size == 2'd0 && dp_wr.hi_byte) begin
            bank_d[b][dp_wr.sel[0]][15:8] = dp_wr.data[7:0];
          end else if (dp_wr.size == 2'd0) begin
            bank_d[b][dp_wr.sel[0]][7:0] = dp_wr.data[7:0];
          end else begin
            bank_d[b][dp_wr.sel[0]] = dp_wr.data[15:0];
          end
        end
        CRF_SEL_D2, CRF_SEL_D3, CRF_SEL_A0, CRF_SEL_A1:
          bank_d[b][dp_wr.sel[2:0]] = dp_wr.data[15:0];
        CRF_SEL_FB: bank_d[b][6] = dp_wr.data[15:0];
        CRF_SEL_SB: sb_d = dp_wr.data[15:0];
        CRF_SEL_SP: begin
          if (flg_q[FLG_U]) usp_d = dp_wr.data[15:0];
          else isp_d = dp_wr.data[15:0];
        end
        CRF_SEL_L_LO: begin
          bank_d[b][0] = dp_wr.data[15:0];
          bank_d[b][2] = dp_wr.data[31:16];
        end
        CRF_SEL_L_HI: begin
          bank_d[b][1] = dp_wr.data[15:0];
          bank_d[b][3] = dp_wr.data[31:16];
        end
        CRF_SEL_L_AD: begin
          bank_d[b][4] = dp_wr.data[15:0];
          bank_d[b][5] = dp_wr.data[31:16];
        end
        default: ;
      endcase
    end
    if (pc_load) pc_d = pc_value;
    // ALU results
    if (alu_upd.en) begin
      flg_d[FLG_C] = alu_upd.carry;
      flg_d[FLG_Z] = alu_upd.zero;
      flg_d[FLG_S] = alu_upd.sign;
      flg_d[FLG_O] = alu_upd.ovf;
    end
    // Acknowledge clears step, enable and stack flags and loads the new level
    if (irq_ev.hw_ack) begin
      flg_d[FLG_D] = 1'b0;
      flg_d[FLG_I] = 1'b0;
      flg_d[FLG_U] = 1'b0;
      flg_d[FLG_IPL_HI:FLG_IPL_LO] = irq_ev.new_ipl;
    end
    if (irq_ev.swi && irq_ev.swi_num <= 6'(SWI_LAST_CLR)) begin
      flg_d[FLG_U] = 1'b0;
    end
    flg_d = flg_d & FLG_MASK;
    // Active pointer from next values, so the registered copy never lags the flag
    sp_d = flg_d[FLG_U] ? usp_d : isp_d;
  end

  // Read mux for the datapath, combined pairs upper half from higher register
  always_comb begin
    logic b;
    b = bank_q_sel;
    rd_d = 32'h00000000;
    case (rd_sel)
      CRF_SEL_D0, CRF_SEL_D1, CRF_SEL_D2, CRF_SEL_D3, CRF_SEL_A0, CRF_SEL_A1,
      CRF_SEL_FB: rd_d = {16'h0000, bank_q[b][rd_sel[2:0]]};
      CRF_SEL_SB: rd_d = {16'h0000, sb_q};
      CRF_SEL_SP: rd_d = {16'h0000, flg_q[FLG_U] ? usp_q : isp_q};
      CRF_SEL_L_LO: rd_d = {bank_q[b][2], bank_q[b][0]};
      CRF_SEL_L_HI: rd_d = {bank_q[b][3], bank_q[b][1]};
      CRF_SEL_L_AD: rd_d = {bank_q[b][5], bank_q[b][4]};
      default: rd_d = 32'h00000000;
    endcase
    // Single step after completion; acceptance strictly above level with enable set
    step_d = insn_done && flg_q[FLG_D];
    accept_d = req_valid && flg_q[FLG_I]
      && (req_level > flg_q[FLG_IPL_HI:FLG_IPL_LO]);
  end

  // Bus read data, driven in the data phase
  always_comb begin
    hrdata_d = 32'h00000000;
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        OFS_DATA0: hrdata_d = {16'h0000, bank_q[bank_q_sel][0]};
        OFS_DATA1: hrdata_d = {16'h0000, bank_q[bank_q_sel][1]};
        OFS_DATA2: hrdata_d = {16'h0000, bank_q[bank_q_sel][2]};
        OFS_DATA3: hrdata_d = {16'h0000, bank_q[bank_q_sel][3]};
        OFS_ADDR0: hrdata_d = {16'h0000, bank_q[bank_q_sel][4]};
        OFS_ADDR1: hrdata_d = {16'h0000, bank_q[bank_q_sel][5]};
        OFS_FRAME: hrdata_d = {16'h0000, bank_q[bank_q_sel][6]};
        OFS_PC: hrdata_d = {12'h000, pc_q};
        OFS_VTB: hrdata_d = {12'h000, vtb_q};
        OFS_USP: hrdata_d = {16'h0000, usp_q};
        OFS_ISP: hrdata_d = {16'h0000, isp_q};
        OFS_SB: hrdata_d = {16'h0000, sb_q};
        OFS_FLAG: hrdata_d = {16'h0000, flg_q};
        default: hrdata_d = 32'h00000000;
      endcase
    end
  end

  // Register stage; reset takes constants only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < 7; k++) begin
        bank_q[0][k] <= RST_W16;
        bank_q[1][k] <= RST_W16;
      end
      usp_q <= RST_W16;
      isp_q <= RST_W16;
      sb_q <= RST_W16;
      pc_q <= RST_W20;
      vtb_q <= RST_W20;
      flg_q <= RST_FLG;
      st_q <= CRF_ST_IDLE;
      ofs_q <= 8'h00;
      wr_q <= 1'b0;
      hrdata <= 32'h00000000;
      rd_data <= 32'h00000000;
      step_irq <= 1'b0;
      irq_accept <= 1'b0;
      sp_out <= RST_W16;
    end else begin
      bank_q <= bank_d;
      usp_q <= usp_d;
      isp_q <= isp_d;
      sb_q <= sb_d;
      pc_q <= pc_d;
      vtb_q <= vtb_d;
      flg_q <= flg_d;
      st_q <= st_d;
      ofs_q <= ofs_d;
      wr_q <= wr_d;
      hrdata <= hrdata_d;
      rd_data <= rd_d;
      step_irq <= step_d;
      irq_accept <= accept_d;
      sp_out <= sp_d;
    end
  end

  // Mirrors of architectural state, straight from flip-flops
  assign flag_out = flg_q;
  assign pc_out = pc_q;
  assign vtb_out = vtb_q;
  // Zero-wait slave: always ready, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Checks
  a_resv_bits_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    (flg_q & ~FLG_MASK) == 16'h0000) else $error("reserved flag bits set");
  a_ack_clears: assert property (@(posedge mclk) disable iff (!rst_n)
    irq_ev.hw_ack |=> !flg_q[FLG_I] && !flg_q[FLG_D] && !flg_q[FLG_U])
    else $error("acknowledge did not clear flags");
  a_swi_clears_u: assert property (@(posedge mclk) disable iff (!rst_n)
    irq_ev.swi && irq_ev.swi_num < 6'd32 |=> !flg_q[FLG_U])
    else $error("software vector did not clear stack flag");
  a_zero_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    alu_upd.en && !irq_ev.hw_ack |=> flg_q[FLG_Z] == $past(alu_upd.zero))
    else $error("zero flag wrong");
  a_carry_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    alu_upd.en |=> flg_q[FLG_C] == $past(alu_upd.carry))
    else $error("carry flag wrong");
  a_step_raise: assert property (@(posedge mclk) disable iff (!rst_n)
    insn_done && flg_q[FLG_D] |=> step_irq) else $error("single step missing");
  a_prio_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    irq_accept |-> $past(req_level) > $past(flg_q[FLG_IPL_HI:FLG_IPL_LO]))
    else $error("low priority accepted");
  a_sp_select: assert property (@(posedge mclk) disable iff (!rst_n)
    sp_out == (flg_q[FLG_U] ? usp_q : isp_q)) else $error("stack pointer select");
  a_byte_keep: assert property (@(posedge mclk) disable iff (!rst_n)
    dp_wr.en && dp_wr.sel == CRF_SEL_D0 && dp_wr.size == 2'd0 && dp_wr.hi_byte
    && !(st_q == CRF_ST_DATA && wr_q)
    |=> bank_q[$past(bank_q_sel)][0][7:0] == $past(bank_q[bank_q_sel][0][7:0]))
    else $error("byte write touched low half");
  // Result flags follow the ALU strobe one edge later
  a_sign_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    alu_upd.en |=> flg_q[FLG_S] == $past(alu_upd.sign))
    else $error("sign flag wrong");
  a_ovf_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    alu_upd.en |=> flg_q[FLG_O] == $past(alu_upd.ovf))
    else $error("overflow flag wrong");
  // No single-step request while the step flag is clear
  a_step_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    !flg_q[FLG_D] |=> !step_irq) else $error("spurious single step");
  // Acceptance needs a pending request and the enable flag
  a_accept_enable: assert property (@(posedge mclk) disable iff (!rst_n)
    irq_accept |-> $past(flg_q[FLG_I]) && $past(req_valid))
    else $error("masked request accepted");
  a_ipl_load: assert property (@(posedge mclk) disable iff (!rst_n)
    irq_ev.hw_ack |=> flg_q[FLG_IPL_HI:FLG_IPL_LO] == $past(irq_ev.new_ipl))
    else $error("priority level not loaded");
  a_top_bit_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    !flg_q[15]) else $error("top flag bit set");
  // Datapath read of the first data register comes from the selected bank
  a_bank_read: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_sel == CRF_SEL_D0 |=> rd_data == {16'h0000, ($past(flg_q[FLG_B])
    ? $past(bank_q[1][0]) : $past(bank_q[0][0]))})
    else $error("bank select on read");
  a_pc_load: assert property (@(posedge mclk) disable iff (!rst_n)
    pc_load |=> pc_q == $past(pc_value)) else $error("program counter load");
  // Read data stands only in a read data phase
  a_hrdata_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    !(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h00000000)
    else $error("read data outside data phase");
  c_step: cover property (@(posedge mclk) disable iff (!rst_n) step_irq);
  c_swi: cover property (@(posedge mclk) disable iff (!rst_n) irq_ev.swi);
  c_ack: cover property (@(posedge mclk) disable iff (!rst_n) irq_ev.hw_ack);
  c_bank1: cover property (@(posedge mclk) disable iff (!rst_n) flg_q[FLG_B]);
  c_accept: cover property (@(posedge mclk) disable iff (!rst_n) irq_accept);
endmodule
`default_nettype wire

/* test/crf_dp_model.sv */
// Behavioural model of the execution datapath and interrupt sequencer
`timescale 1ns/10ps
`default_nettype none
module crf_dp_model
  import crf_pkg::*;
(
  input wire logic mclk,
  output var crf_wr_type dp_wr,
  output var crf_alu_type alu_upd,
  output logic pc_load,
  output logic [19:0] pc_value,
  output logic insn_done,
  output var crf_irq_type irq_ev,
  output logic [2:0] req_level,
  output logic req_valid,
  output var crf_sel_type rd_sel
);
  // Idle values at time zero; every task is entered just after a rising edge
  initial begin
    dp_wr = '0;
    alu_upd = '0;
    pc_load = 1'b0;
    pc_value = 20'h00000;
    insn_done = 1'b0;
    irq_ev = '0;
    req_level = 3'h0;
    req_valid = 1'b0;
    rd_sel = CRF_SEL_D0;
  end
  // One-cycle strobes, so the register file sees each event exactly once
  task automatic dp_write(crf_sel_type s, logic [1:0] sz, logic hi, logic [31:0] d);
    dp_wr <= '{en: 1'b1, sel: s, size: sz, hi_byte: hi, data: d};
    @(posedge mclk);
    dp_wr.en <= 1'b0;
  endtask
  task automatic alu(logic c, logic z, logic s, logic o);
    alu_upd <= '{en: 1'b1, carry: c, zero: z, sign: s, ovf: o};
    @(posedge mclk);
    alu_upd.en <= 1'b0;
  endtask
  task automatic load_pc(logic [19:0] v);
    pc_load <= 1'b1;
    pc_value <= v;
    @(posedge mclk);
    pc_load <= 1'b0;
  endtask
  task automatic done_pulse();
    insn_done <= 1'b1;
    @(posedge mclk);
    insn_done <= 1'b0;
  endtask
  task automatic irq(logic hw, logic sw, logic [5:0] num, logic [2:0] cpu_priority_level);
    irq_ev <= '{hw_ack: hw, swi: sw, swi_num: num, new_ipl: cpu_priority_level};
    @(posedge mclk);
    irq_ev <= '0;
  endtask
  // Request stays pending until the sequencer withdraws it
  task automatic request(logic v, logic [2:0] lvl);
    req_valid <= v;
    req_level <= lvl;
    @(posedge mclk);
  endtask
  task automatic dp_rd(crf_sel_type s);
    rd_sel <= s;
    @(posedge mclk);
  endtask
endmodule
`default_nettype wire

/* test/cpu_register_file_flags_tb.sv */
// Self-checking bench for the register file and flag word
`timescale 1ns/10ps
`default_nettype none
module cpu_register_file_flags_tb;
  import crf_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hsel = 1'b0;
  wire logic hready;
  logic [31:0] hrdata, rd_data;
  logic hreadyout, hresp, pc_load, insn_done, req_valid, step_irq, irq_accept;
  logic [19:0] pc_value, pc_out, vtb_out;
  logic [15:0] flag_out, sp_out;
  logic [2:0] req_level;
  crf_wr_type dp_wr;
  crf_alu_type alu_upd;
  crf_irq_type irq_ev;
  crf_sel_type rd_sel;
  int n_fail = 0;
  int cmp_count = 0;
  int seed = 47;
  logic rd_dph = 1'b0;
  logic [31:0] expq[$];
  logic [7:0] ofs [13] = '{OFS_DATA0, OFS_DATA1, OFS_DATA2, OFS_DATA3, OFS_ADDR0,
    OFS_ADDR1, OFS_FRAME, OFS_PC, OFS_VTB, OFS_USP, OFS_ISP, OFS_SB, OFS_FLAG};
  logic [31:0] msk [13] = '{32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF,
    32'hFFFF, 32'hFFFFF, 32'hFFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'h70FF};
  always #5 mclk = ~mclk;
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  crf_core u_crf_core (.mclk(mclk), .rst_n(rst_n), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hsel(hsel), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dp_wr(dp_wr),
    .alu_upd(alu_upd), .pc_load(pc_load), .pc_value(pc_value), .insn_done(insn_done),
    .irq_ev(irq_ev), .req_level(req_level), .req_valid(req_valid), .rd_sel(rd_sel),
    .rd_data(rd_data), .flag_out(flag_out), .pc_out(pc_out), .vtb_out(vtb_out),
    .sp_out(sp_out), .step_irq(step_irq), .irq_accept(irq_accept));
  crf_dp_model u_crf_dp_model (.mclk(mclk), .dp_wr(dp_wr), .alu_upd(alu_upd),
    .pc_load(pc_load), .pc_value(pc_value), .insn_done(insn_done), .irq_ev(irq_ev),
    .req_level(req_level), .req_valid(req_valid), .rd_sel(rd_sel));
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Address phase held until ready, then data phase held until ready
  task automatic ahb(logic wr, logic [7:0] a, logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsel <= 1'b1;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
  endtask
  task automatic ahb_read(logic [7:0] a, logic [31:0] e);
    expq.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask
  task automatic long_chk(crf_sel_type s, logic [7:0] oh, logic [7:0] ol);
    logic [31:0] w;
    w = $random(seed);
    u_crf_dp_model.dp_write(s, 2'd2, 1'b0, w);
    ahb_read(oh, {16'h0, w[31:16]});
    ahb_read(ol, {16'h0, w[15:0]});
    u_crf_dp_model.dp_rd(s);
    #1 chk("rd_data long", rd_data, w);
  endtask
  // Read data is taken at the edge that ends the data phase
  always @(posedge mclk) begin
    if (rd_dph && hready && expq.size() > 0) chk("hrdata", hrdata, expq.pop_front());
    if (rd_dph) chk("hresp", {31'h0, hresp}, 32'h0);
    rd_dph = hsel && htrans[1] && !hwrite && hready;
  end
  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    finish_test();
  end
  initial begin
    logic [31:0] v;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 13; i++) ahb_read(ofs[i], 32'h0);
    // Random fill of every register; flag word last since it moves the bank
    for (int i = 0; i < 13; i++) begin
      v = $random(seed);
      ahb(1'b1, ofs[i], v);
      ahb_read(ofs[i], v & msk[i]);
    end
    ahb(1'b1, OFS_FLAG, 32'h0);
    ahb(1'b1, 8'h34, 32'hFFFFFFFF);
    ahb_read(8'h34, 32'h0);
    // Bank switch: the other copy is untouched, then the first comes back; then byte writes, long pairs, PC and VTB
    ahb(1'b1, OFS_DATA0, 32'hA5A5);
    ahb(1'b1, OFS_FLAG, 32'h10);
    ahb_read(OFS_DATA0, 32'h0);
    ahb(1'b1, OFS_DATA0, 32'h5A5A);
    ahb(1'b1, OFS_FLAG, 32'h0);
    ahb_read(OFS_DATA0, 32'hA5A5);
    u_crf_dp_model.dp_write(CRF_SEL_D1, 2'd1, 1'b0, 32'h1234);
    u_crf_dp_model.dp_write(CRF_SEL_D1, 2'd0, 1'b1, 32'h7E7E);
    ahb_read(OFS_DATA1, 32'h7E34);
    u_crf_dp_model.dp_write(CRF_SEL_D1, 2'd0, 1'b0, 32'hC3C3);
    ahb_read(OFS_DATA1, 32'h7EC3);
    long_chk(CRF_SEL_L_LO, OFS_DATA2, OFS_DATA0);
    long_chk(CRF_SEL_L_HI, OFS_DATA3, OFS_DATA1);
    long_chk(CRF_SEL_L_AD, OFS_ADDR1, OFS_ADDR0);
    v = $random(seed);
    u_crf_dp_model.load_pc(v[19:0]);
    #1 chk("pc_out", {12'h0, pc_out}, v & 32'hFFFFF);
    ahb_read(OFS_PC, v & 32'hFFFFF);
    ahb(1'b1, OFS_VTB, ~v);
    #1 chk("vtb_out", {12'h0, vtb_out}, ~v & 32'hFFFFF);
    // Stack pointer choice follows the stack select flag
    ahb(1'b1, OFS_USP, 32'h1111);
    ahb(1'b1, OFS_ISP, 32'h2222);
    #1 chk("sp_out isp", {16'h0, sp_out}, 32'h2222);
    ahb(1'b1, OFS_FLAG, 32'h80);
    #1 chk("sp_out usp", {16'h0, sp_out}, 32'h1111);
    u_crf_dp_model.dp_write(CRF_SEL_SP, 2'd1, 1'b0, 32'h3333);
    #1 chk("sp_out dp", {16'h0, sp_out}, 32'h3333);
    ahb_read(OFS_ISP, 32'h2222);
    // Single step, hardware acknowledge and software vectors 30 to 33
    ahb(1'b1, OFS_FLAG, 32'hC2);
    u_crf_dp_model.done_pulse();
    #1 chk("step_irq", {31'h0, step_irq}, 32'h1);
    u_crf_dp_model.irq(1'b1, 1'b0, 6'h0, 3'h5);
    #1 chk("flag ack", {16'h0, flag_out & 16'h70C0}, 32'h5000);
    for (int i = 30; i < 34; i++) begin
      ahb(1'b1, OFS_FLAG, 32'h80);
      u_crf_dp_model.irq(1'b0, 1'b1, i[5:0], 3'h0);
      #1 chk("flag swi", {31'h0, flag_out[7]}, (i > 31) ? 32'h1 : 32'h0);
    end
    ahb(1'b1, OFS_FLAG, 32'h0);
    u_crf_dp_model.done_pulse();
    #1 chk("step_irq off", {31'h0, step_irq}, 32'h0);
    // Priority compare against a level of three, then with interrupts off
    ahb(1'b1, OFS_FLAG, 32'h3040);
    for (int i = 0; i < 8; i++) begin
      u_crf_dp_model.request(1'b1, i[2:0]);
      #1 chk("irq_accept", {31'h0, irq_accept}, (i > 3) ? 32'h1 : 32'h0);
    end
    ahb(1'b1, OFS_FLAG, 32'h3000);
    u_crf_dp_model.request(1'b1, 3'h7);
    #1 chk("irq_accept off", {31'h0, irq_accept}, 32'h0);
    u_crf_dp_model.request(1'b0, 3'h0);
    #1 chk("ipl field", {29'h0, flag_out[14:12]}, 32'h3);
    ahb(1'b1, OFS_FLAG, 32'h0);
    // Every combination of result flags; other bits must stay clear
    for (int i = 0; i < 16; i++) begin
      u_crf_dp_model.alu(i[0], i[1], i[2], i[3]);
      #1 chk("flag alu", {16'h0, flag_out}, {26'h0, i[3], 1'b0, i[2], i[1], 1'b0, i[0]});
    end
    repeat (3) @(posedge mclk);
    finish_test();
  end
endmodule
`default_nettype wire
